// File: eoihp_access_check.sv
// Decides the fate of one access: undefined, trapped, redirected or taken.
// Assumes the caller feeds the routing bits of its group.
`timescale 1ns/100ps
module eoihp_access_check
    import eoihp_pkg::*;
(
    // Current context
    input  wire logic [1:0] cur_el,
    input  wire logic       nonsecure,
    input  wire logic       el3_present,
    // Control bits
    input  wire logic       sre_el1,
    input  wire logic       sre_el2,
    input  wire logic       sre_el3,
    input  wire logic       hyp_route,
    input  wire logic       trap_general_exceptions,
    input  wire logic       trap_all,
    input  wire logic       mon_route,
    // Outcome
    output eoihp_acc_t      outcome,
    output logic [1:0]      trap_el
);

    logic ns_kernel;    // Non-secure EL1
    logic not_avail;    // No access in this context
    logic sre_off;      // Interface disabled at current level
    logic tall_trap;    // Hypervisor trap-all
    logic mon_trap;     // Monitor routing trap

    assign ns_kernel = nonsecure && (cur_el == EL1);
    // EL0, hypervisor-owned kernel, or secure EL2 give no access
    assign not_avail = (cur_el == EL0) || (ns_kernel && trap_general_exceptions)
                       || (!nonsecure && (cur_el == EL2));
    assign sre_off   = ((cur_el == EL1) && !sre_el1) || ((cur_el == EL2) && !sre_el2)
                       || ((cur_el == EL3) && !sre_el3);
    assign tall_trap = ns_kernel && trap_all;
    assign mon_trap  = el3_present && mon_route
                       && (((cur_el == EL1) && !nonsecure) || (cur_el == EL2)
                           || (ns_kernel && !hyp_route));

    // Priority: unavailable, enable trap, trap-all, monitor, redirect
    always_comb begin
        outcome = EOIHP_ACC_OK;
        trap_el = EL0;
        if (not_avail) begin
            outcome = EOIHP_ACC_UNDEF;
        end else if (sre_off) begin
            outcome = EOIHP_ACC_TRAP;
            trap_el = cur_el;
        end else if (tall_trap) begin
            outcome = EOIHP_ACC_TRAP;
            trap_el = EL2;
        end else if (mon_trap) begin
            outcome = EOIHP_ACC_TRAP;
            trap_el = EL3;
        end else if (ns_kernel && hyp_route) begin
            outcome = EOIHP_ACC_VIRT;
        end
    end

endmodule : eoihp_access_check

// File: eoihp_core_model.sv
// Behavioural core issuing register instructions.
// Assumes the bench calls issue() from one process at a time.
`timescale 1ns/100ps
module eoihp_core_model
    import eoihp_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Request to the block
    output logic             req_valid,
    output logic             req_write,
    output logic [OP1_W-1:0] req_op1,
    output logic [CRN_W-1:0] req_crn,
    output logic [CRM_W-1:0] req_crm,
    output logic [OP2_W-1:0] req_op2,
    output logic [REG_W-1:0] req_wdata
);
    // Idle request, scrambled data at time zero
    initial begin
        {req_valid, req_write, req_op1, req_crn, req_crm, req_op2, req_wdata} = {2'h0, 14'h0000, 32'h5a5a_5a5a};
    end
    // One request per call, launched and dropped on falling edges
    task automatic issue(input logic w, input logic [13:0] enc, input logic [31:0] d);
        @(negedge clk);
        {req_valid, req_write, req_op1, req_crn, req_crm, req_op2, req_wdata} = {1'b1, w, enc, d};
        @(negedge clk);
        // Released lines other than req_write do not keep their last value
        {req_valid, req_op1, req_crn, req_crm, req_op2, req_wdata} = {1'b0, ~enc, ~d};
    endtask : issue
endmodule : eoihp_core_model

// File: eoihp_enc_match.sv
// Matches one system-register encoding against a fixed pattern.
// Assumes the encoding fields are stable while the request is valid.
`timescale 1ns/100ps
module eoihp_enc_match
    import eoihp_pkg::*;
#(
    parameter logic [2:0] P_OP1 = 3'h0,
    parameter logic [3:0] P_CRN = 4'h0,
    parameter logic [3:0] P_CRM = 4'h0,
    parameter logic [2:0] P_OP2 = 3'h0
) (
    // Encoding
    input  wire logic [OP1_W-1:0] op1,
    input  wire logic [CRN_W-1:0] crn,
    input  wire logic [CRM_W-1:0] crm,
    input  wire logic [OP2_W-1:0] op2,
    // Result
    output logic                  hit
);

    // All four fields must agree
    assign hit = (op1 == P_OP1) && (crn == P_CRN) && (crm == P_CRM) && (op2 == P_OP2);

endmodule : eoihp_enc_match

// File: eoihp_pkg.sv
// Constants, encodings and types of the completion / pending-read block.
// Assumes one clock domain shared with the core.
// Summary of operation
// - Completion register: 32 bits, identifier in 23:0
// - Identifier 16 or 24 bits; upper zero
// - Mode 0: write drops priority and deactivates
// - Mode 1: drop only; software deactivates separately
// - Mode bit chosen by monitor presence, level, state
// - Completion write encoding 000/1100/1100/001
// - Non-secure kernel with irq route: virtual completion
// - Completion write-only EL1-3, none at EL0
// - Special identifier writes neither drop nor deactivate; access checks still apply
// - Interface disabled at level traps to that level
// - Trap-all-group1 traps non-secure kernel writes to EL2
// - Monitor irq route traps writes to EL3
// - Pending read returns Group 0 identifier, upper zero
// - Unobservable pending returns 1020, 1021 or 1023
// - Pending read encoding 000/1100/1000/010
// - Fiq route redirects pending read to virtual
// - Interface disabled at level traps pending reads
// - Trap-all-group0 traps non-secure kernel reads to EL2
// - Monitor fiq route traps pending reads to EL3
package eoihp_pkg;

    // Encoding field widths
    localparam int OP1_W = 3;
    localparam int CRN_W = 4;
    localparam int CRM_W = 4;
    localparam int OP2_W = 3;

    // Completion register encoding
    localparam logic [2:0] EOI1_OP1 = 3'h0;
    localparam logic [3:0] EOI1_CRN = 4'hc;
    localparam logic [3:0] EOI1_CRM = 4'hc;
    localparam logic [2:0] EOI1_OP2 = 3'h1;

    // Group 0 pending register encoding
    localparam logic [2:0] HPP0_OP1 = 3'h0;
    localparam logic [3:0] HPP0_CRN = 4'hc;
    localparam logic [3:0] HPP0_CRM = 4'h8;
    localparam logic [2:0] HPP0_OP2 = 3'h2;

    // Register layout
    localparam int REG_W       = 32;
    localparam int ID_W        = 24;
    localparam int ID_NARROW_W = 16;
    localparam int ID_LSB      = 0;

    // Special identifiers
    localparam logic [23:0] ID_SPECIAL_LO = 24'h0003fc;  // 1020
    localparam logic [23:0] ID_SPECIAL_HI = 24'h0003ff;  // 1023
    localparam logic [23:0] ID_SPEC_1020  = 24'h0003fc;
    localparam logic [23:0] ID_SPEC_1021  = 24'h0003fd;
    localparam logic [23:0] ID_SPEC_1023  = 24'h0003ff;

    // Exception level codes
    localparam logic [1:0] EL0 = 2'h0;
    localparam logic [1:0] EL1 = 2'h1;
    localparam logic [1:0] EL2 = 2'h2;
    localparam logic [1:0] EL3 = 2'h3;

    // Reset values of response outputs
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [23:0] ID_RST    = 24'h00_0000;

    // Outcome of an access attempt
    typedef enum logic [2:0] {
        EOIHP_ACC_NONE,
        EOIHP_ACC_UNDEF,
        EOIHP_ACC_TRAP,
        EOIHP_ACC_VIRT,
        EOIHP_ACC_OK
    } eoihp_acc_t;

    // Pending-state reason for the read path
    typedef enum logic [1:0] {
        EOIHP_HP_VALID,
        EOIHP_HP_1020,
        EOIHP_HP_1021,
        EOIHP_HP_1023
    } eoihp_hp_t;

endpackage : eoihp_pkg

// File: eoihp_properties.sv
// Port-level checks of the register block.
// Assumes one clock domain and a fixed one-cycle answer.
`timescale 1ns/100ps
module eoihp_properties
    import eoihp_pkg::*;
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst_n,
    // Request and context
    input wire logic             req_valid,
    input wire logic             req_write,
    input wire logic [OP1_W-1:0] req_op1,
    input wire logic [CRN_W-1:0] req_crn,
    input wire logic [CRM_W-1:0] req_crm,
    input wire logic [OP2_W-1:0] req_op2,
    input wire logic [REG_W-1:0] req_wdata,
    input wire logic [1:0]       cur_el,
    input wire logic             sysreg_enable_monitor,
    input wire logic             identifier_width_24,
    input wire logic [ID_W-1:0]  hp_group0_id,
    input wire eoihp_hp_t        hp_group0_reason,
    // Answer
    input wire logic             resp_valid,
    input wire logic [REG_W-1:0] resp_rdata,
    input wire logic             resp_undef,
    input wire logic             prio_drop,
    input wire logic             deactivate,
    input wire logic [ID_W-1:0]  done_id
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Encodings on the request
    wire logic eoi_hit = {req_op1, req_crn, req_crm, req_op2} == {EOI1_OP1, EOI1_CRN, EOI1_CRM, EOI1_OP2};
    wire logic hpp_hit = {req_op1, req_crn, req_crm, req_op2} == {HPP0_OP1, HPP0_CRN, HPP0_CRM, HPP0_OP2};
    // Accepted pending read at the monitor level
    sequence s_mon_read;
        req_valid && !req_write && hpp_hit && cur_el == EL3 && sysreg_enable_monitor;
    endsequence
    // Special identifier in the data of any write, whatever its encoding
    sequence s_spec_write;
        req_valid && req_write && req_wdata[23:0] >= ID_SPECIAL_LO && req_wdata[23:0] <= ID_SPECIAL_HI;
    endsequence
    a_answer_next: assert property (req_valid |=> resp_valid) else $error("no answer");
    a_upper_zero: assert property (resp_valid |-> resp_rdata[31:24] == 8'h00) else $error("upper bits");
    a_drop_cause: assert property (prio_drop |-> $past(req_valid && req_write && eoi_hit)) else $error("drop");
    a_deact_drop: assert property (deactivate |-> prio_drop) else $error("deactivate alone");
    a_el0_refused: assert property (req_valid && cur_el == EL0 |=> resp_undef && !prio_drop) else $error("el0");
    a_read_quiet: assert property (req_valid && !req_write |=> !prio_drop && $stable(done_id)) else $error("rd");
    a_special_ign: assert property (s_spec_write |=> !prio_drop && $stable(done_id)) else $error("special");
    a_drop_id: assert property (prio_drop && $past(identifier_width_24) |-> done_id == $past(req_wdata[23:0]))
        else $error("completed id");
    a_pend_data: assert property (s_mon_read ##0 identifier_width_24 && hp_group0_reason == EOIHP_HP_VALID
        |=> resp_rdata == {8'h00, $past(hp_group0_id)}) else $error("pending id");
    a_pend_1023: assert property (s_mon_read ##0 hp_group0_reason == EOIHP_HP_1023
        |=> resp_rdata == {8'h00, ID_SPEC_1023}) else $error("pending 1023");
endmodule : eoihp_properties

bind eoihp_sysregs eoihp_properties i_eoihp_properties (.*);

// File: eoihp_sysregs.sv
// Top of the completion / Group 0 pending register block.
// One register instruction per request, answered a cycle later;
// completions raise a priority-drop pulse, plus a deactivate pulse in mode 0.
// Assumes all inputs come from logic on clk, with the control
// bits live from the core's configuration registers.
`timescale 1ns/100ps
module eoihp_sysregs
    import eoihp_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Request from the core
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [OP1_W-1:0]  req_op1,
    input  wire logic [CRN_W-1:0]  req_crn,
    input  wire logic [CRM_W-1:0]  req_crm,
    input  wire logic [OP2_W-1:0]  req_op2,
    input  wire logic [REG_W-1:0]  req_wdata,
    // Execution context
    input  wire logic [1:0]        cur_el,
    input  wire logic              nonsecure_state_flag,
    input  wire logic              el3_present,
    // Completion mode bits
    input  wire logic              completion_split_mode,
    input  wire logic              completion_split_mode_monitor,
    input  wire logic              completion_split_mode_secure_kernel,
    input  wire logic              completion_split_mode_nonsecure_kernel,
    input  wire logic              identifier_width_24,
    // Interface enables
    input  wire logic              sysreg_enable_kernel,
    input  wire logic              sysreg_enable_hyp,
    input  wire logic              sysreg_enable_monitor,
    // Hypervisor and monitor routing
    input  wire logic              hyp_irq_route,
    input  wire logic              hyp_fiq_route,
    input  wire logic              trap_general_exceptions,
    input  wire logic              trap_all_group1,
    input  wire logic              trap_all_group0,
    input  wire logic              monitor_irq_route,
    input  wire logic              monitor_fast_irq_route,
    // Highest pending Group 0 from the prioritiser
    input  wire logic [ID_W-1:0]   hp_group0_id,
    input  wire eoihp_hp_t         hp_group0_reason,
    // Answer to the core
    output logic                   resp_valid,
    output logic [REG_W-1:0]       resp_rdata,
    output logic                   resp_undef,
    output logic                   resp_trap,
    output logic [1:0]             resp_trap_el,
    output logic                   resp_virtual,
    // Actions on the interrupt state
    output logic                   prio_drop,
    output logic                   deactivate,
    output logic [ID_W-1:0]        done_id
);

    // Encoding hits
    logic             eoi_hit;       // Completion encoding seen
    logic             hpp_hit;       // Pending-read encoding seen
    // Access outcomes
    eoihp_acc_t       eoi_outcome;   // Fate of a completion write
    eoihp_acc_t       hpp_outcome;   // Fate of a pending read
    logic [1:0]       eoi_trap_el;   // Target level, completion
    logic [1:0]       hpp_trap_el;   // Target level, pending read
    // Decoded request
    logic             eoi_req;       // Valid completion write
    logic             hpp_req;       // Valid pending read
    logic             unmapped;      // Wrong direction or other encoding
    eoihp_acc_t       sel_outcome;   // Outcome of the selected register
    logic [1:0]       sel_trap_el;   // Trap target of the selected register
    // Completion datapath
    logic [ID_W-1:0]  wr_id;         // Identifier after width masking
    logic             wr_special;    // Identifier is 1020 to 1023
    logic             split_mode;    // Applicable mode bit
    logic             eoi_act;       // Completion takes effect
    // Pending datapath
    logic [ID_W-1:0]  hp_id_masked;  // Valid identifier after masking
    logic [ID_W-1:0]  hp_id_sel;     // Identifier or special code
    logic [REG_W-1:0] rd_word;       // Word returned on a read
    // Registered outputs
    logic             resp_valid_q,   resp_valid_d;
    logic [REG_W-1:0] resp_rdata_q,   resp_rdata_d;
    logic             resp_undef_q,   resp_undef_d;
    logic             resp_trap_q,    resp_trap_d;
    logic [1:0]       resp_trap_el_q, resp_trap_el_d;
    logic             resp_virtual_q, resp_virtual_d;
    logic             prio_drop_q,    prio_drop_d;
    logic             deactivate_q,   deactivate_d;
    logic [ID_W-1:0]  done_id_q,      done_id_d;

    // Completion register encoding
    eoihp_enc_match #(
        .P_OP1 (EOI1_OP1),
        .P_CRN (EOI1_CRN),
        .P_CRM (EOI1_CRM),
        .P_OP2 (EOI1_OP2)
    ) u_eoi_match (
        .op1 (req_op1),
        .crn (req_crn),
        .crm (req_crm),
        .op2 (req_op2),
        .hit (eoi_hit)
    );

    // Group 0 pending register encoding
    eoihp_enc_match #(
        .P_OP1 (HPP0_OP1),
        .P_CRN (HPP0_CRN),
        .P_CRM (HPP0_CRM),
        .P_OP2 (HPP0_OP2)
    ) u_hpp_match (
        .op1 (req_op1),
        .crn (req_crn),
        .crm (req_crm),
        .op2 (req_op2),
        .hit (hpp_hit)
    );

    // Completion path follows the irq routing and Group 1 trap
    eoihp_access_check u_eoi_check (
        .cur_el                  (cur_el),
        .nonsecure               (nonsecure_state_flag),
        .el3_present             (el3_present),
        .sre_el1                 (sysreg_enable_kernel),
        .sre_el2                 (sysreg_enable_hyp),
        .sre_el3                 (sysreg_enable_monitor),
        .hyp_route               (hyp_irq_route),
        .trap_general_exceptions (trap_general_exceptions),
        .trap_all                (trap_all_group1),
        .mon_route               (monitor_irq_route),
        .outcome                 (eoi_outcome),
        .trap_el                 (eoi_trap_el)
    );

    // Pending path follows the fiq routing and Group 0 trap
    eoihp_access_check u_hpp_check (
        .cur_el                  (cur_el),
        .nonsecure               (nonsecure_state_flag),
        .el3_present             (el3_present),
        .sre_el1                 (sysreg_enable_kernel),
        .sre_el2                 (sysreg_enable_hyp),
        .sre_el3                 (sysreg_enable_monitor),
        .hyp_route               (hyp_fiq_route),
        .trap_general_exceptions (trap_general_exceptions),
        .trap_all                (trap_all_group0),
        .mon_route               (monitor_fast_irq_route),
        .outcome                 (hpp_outcome),
        .trap_el                 (hpp_trap_el)
    );

    // Direction check: completion is write-only, pending is read-only
    assign eoi_req  = req_valid && eoi_hit && req_write;
    assign hpp_req  = req_valid && hpp_hit && !req_write;
    assign unmapped = req_valid && !eoi_req && !hpp_req;

    // Outcome of whichever register was addressed
    assign sel_outcome = eoi_req ? eoi_outcome : (hpp_req ? hpp_outcome : EOIHP_ACC_NONE);
    assign sel_trap_el = eoi_req ? eoi_trap_el : hpp_trap_el;

    // Identifier width: narrow mode clears bits 23:16
    assign wr_id = identifier_width_24 ? req_wdata[ID_W-1:ID_LSB]
                 : {8'h00, req_wdata[ID_NARROW_W-1:ID_LSB]};

    // Special identifiers 1020 to 1023 change nothing
    assign wr_special = (wr_id >= ID_SPECIAL_LO) && (wr_id <= ID_SPECIAL_HI);

    // Mode bit by monitor presence, level and security state
    assign split_mode = !el3_present           ? completion_split_mode
                      : (cur_el == EL3)        ? completion_split_mode_monitor
                      : nonsecure_state_flag   ? completion_split_mode_nonsecure_kernel
                      :                          completion_split_mode_secure_kernel;

    // Only accepted, non-special writes complete
    assign eoi_act = eoi_req && (eoi_outcome == EOIHP_ACC_OK) && !wr_special;

    // Pending identifier masked to the implemented width
    assign hp_id_masked = identifier_width_24 ? hp_group0_id
                        : {8'h00, hp_group0_id[ID_NARROW_W-1:ID_LSB]};

    // Special code when nothing observable is pending
    always_comb begin
        unique case (hp_group0_reason)
            EOIHP_HP_VALID: hp_id_sel = hp_id_masked;
            EOIHP_HP_1020:  hp_id_sel = ID_SPEC_1020;
            EOIHP_HP_1021:  hp_id_sel = ID_SPEC_1021;
            EOIHP_HP_1023:  hp_id_sel = ID_SPEC_1023;
        endcase
    end

    // Upper byte always reads as zero
    assign rd_word = {8'h00, hp_id_sel};

    // Next values of the response outputs
    always_comb begin
        resp_valid_d   = req_valid;
        resp_rdata_d   = RDATA_RST;
        resp_undef_d   = 1'b0;
        resp_trap_d    = 1'b0;
        resp_trap_el_d = EL0;
        resp_virtual_d = 1'b0;
        if (unmapped) begin
            // Bad direction or encoding is undefined
            resp_undef_d = 1'b1;
        end else begin
            unique case (sel_outcome)
                EOIHP_ACC_UNDEF: resp_undef_d = 1'b1;
                EOIHP_ACC_TRAP: begin
                    resp_trap_d    = 1'b1;
                    resp_trap_el_d = sel_trap_el;
                end
                EOIHP_ACC_VIRT:  resp_virtual_d = 1'b1;
                EOIHP_ACC_OK: begin
                    // Read returns data only
                    if (hpp_req) begin
                        resp_rdata_d = rd_word;
                    end
                end
                EOIHP_ACC_NONE:  resp_valid_d = req_valid;
            endcase
        end
    end

    // Completion actions
    assign prio_drop_d  = eoi_act;
    assign deactivate_d = eoi_act && !split_mode;
    assign done_id_d    = eoi_act ? wr_id : done_id_q;

    // Response and action registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_q   <= 1'b0;
            resp_rdata_q   <= RDATA_RST;
            resp_undef_q   <= 1'b0;
            resp_trap_q    <= 1'b0;
            resp_trap_el_q <= EL0;
            resp_virtual_q <= 1'b0;
            prio_drop_q    <= 1'b0;
            deactivate_q   <= 1'b0;
            done_id_q      <= ID_RST;
        end else begin
            resp_valid_q   <= resp_valid_d;
            resp_rdata_q   <= resp_rdata_d;
            resp_undef_q   <= resp_undef_d;
            resp_trap_q    <= resp_trap_d;
            resp_trap_el_q <= resp_trap_el_d;
            resp_virtual_q <= resp_virtual_d;
            prio_drop_q    <= prio_drop_d;
            deactivate_q   <= deactivate_d;
            done_id_q      <= done_id_d;
        end
    end

    // Outputs straight from flip-flops
    assign resp_valid   = resp_valid_q;
    assign resp_rdata   = resp_rdata_q;
    assign resp_undef   = resp_undef_q;
    assign resp_trap    = resp_trap_q;
    assign resp_trap_el = resp_trap_el_q;
    assign resp_virtual = resp_virtual_q;
    assign prio_drop    = prio_drop_q;
    assign deactivate   = deactivate_q;
    assign done_id      = done_id_q;

endmodule : eoihp_sysregs

// File: tb.sv
// Self-checking bench for the completion / pending-read block.
// Assumes a one-cycle answer.
`timescale 1ns/100ps
module tb;
    import eoihp_pkg::*;
    localparam logic [13:0] EOI_ENC = {EOI1_OP1, EOI1_CRN, EOI1_CRM, EOI1_OP2};
    localparam logic [13:0] HPP_ENC = {HPP0_OP1, HPP0_CRN, HPP0_CRM, HPP0_OP2};
    // Block ports
    logic        clk, rst_n, req_valid, req_write, nonsecure_state_flag, el3_present;
    logic [2:0]  req_op1, req_op2;
    logic [3:0]  req_crn, req_crm;
    logic [31:0] req_wdata, resp_rdata;
    logic [1:0]  cur_el, resp_trap_el;
    logic        completion_split_mode, completion_split_mode_monitor, identifier_width_24;
    logic        completion_split_mode_secure_kernel, completion_split_mode_nonsecure_kernel;
    logic        sysreg_enable_kernel, sysreg_enable_hyp, sysreg_enable_monitor;
    logic        hyp_irq_route, hyp_fiq_route, trap_general_exceptions, trap_all_group1;
    logic        trap_all_group0, monitor_irq_route, monitor_fast_irq_route;
    logic [23:0] hp_group0_id, done_id;
    eoihp_hp_t   hp_group0_reason;
    logic        resp_valid, resp_undef, resp_trap, resp_virtual, prio_drop, deactivate;
    // Bench knobs
    logic [3:0]  mode_v;
    logic [6:0]  kb;
    logic        wr_grp;
    int          num_errors = 0, n_checks = 0;
    assign {completion_split_mode, completion_split_mode_monitor, completion_split_mode_secure_kernel,
            completion_split_mode_nonsecure_kernel} = mode_v;
    assign {trap_general_exceptions, sysreg_enable_monitor, sysreg_enable_hyp, sysreg_enable_kernel} = kb[3:0];
    // Routes reach only the group under test
    assign {monitor_irq_route, trap_all_group1, hyp_irq_route} = kb[6:4] & {3{wr_grp}};
    assign {monitor_fast_irq_route, trap_all_group0, hyp_fiq_route} = kb[6:4] & {3{~wr_grp}};
    eoihp_sysregs i_eoihp_sysregs (.*);
    eoihp_core_model i_eoihp_core_model (.*);
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // One request; returns in its answer cycle
    task automatic go(input logic w, input logic [13:0] enc, input logic [31:0] d);
        i_eoihp_core_model.issue(w, enc, d);
    endtask : go
    task automatic ctx(input logic [1:0] el, input logic ns, input logic e3, input logic [6:0] k);
        {cur_el, nonsecure_state_flag, el3_present, kb} = {el, ns, e3, k};
    endtask : ctx
    // Mode bit 1 drops only, 0 also deactivates
    task automatic mode_case(input logic [1:0] el, input logic ns, input logic e3, input logic [3:0] sel);
        logic [31:0] d;
        ctx(el, ns, e3, 7'h07);
        for (int k = 0; k < 2; k++) begin
            mode_v = k ? ~sel : sel;
            d = {8'ha5, 15'h0, el, ns, e3, sel, k[0]};
            go(1'b1, EOI_ENC, d);
            chk("drop", {30'h0, prio_drop, deactivate}, {30'h0, 1'b1, k[0]});
            chk("done id", {8'h0, done_id}, {8'h0, d[23:0]});
        end
    endtask : mode_case
    // Width and special identifiers
    task automatic sc_ids;
        ctx(EL1, 1'b0, 1'b1, 7'h07);
        for (int k = 0; k < 2; k++) begin
            identifier_width_24 = k[0];
            go(1'b1, EOI_ENC, 32'hffab_cdef);
            chk("width", {8'h0, done_id}, k ? 32'h00ab_cdef : 32'h0000_cdef);
        end
        for (int s = 0; s < 4; s++) begin
            go(1'b1, EOI_ENC, 32'h0000_03fc + s);
            chk("special", {resp_valid, prio_drop, deactivate, 5'h0, done_id}, 32'h80ab_cdef);
        end
    endtask : sc_ids
    // Both directions; ex is {undef, trap, virtual}
    task automatic acc(input logic [1:0] el, input logic ns, input logic e3, input logic [6:0] k,
                       input logic [2:0] ex, input logic [1:0] tel);
        ctx(el, ns, e3, k);
        for (int w = 0; w < 2; w++) begin
            wr_grp = w[0];
            go(w[0], w ? EOI_ENC : HPP_ENC, 32'h0000_0040);
            chk("access", {25'h0, resp_valid, resp_undef, resp_trap, resp_virtual, resp_trap_el, prio_drop},
                {25'h0, 1'b1, ex, tel, w[0] && ex == 3'h0});
        end
    endtask : acc
    // Pending read, narrow width, refused encodings
    task automatic sc_pend;
        logic [23:0] exp_id [4] = '{24'h12_3456, ID_SPEC_1020, ID_SPEC_1021, ID_SPEC_1023};
        ctx(EL3, 1'b0, 1'b1, 7'h07);
        hp_group0_id = 24'h12_3456;
        for (int r = 0; r < 4; r++) begin
            hp_group0_reason = eoihp_hp_t'(r);
            go(1'b0, HPP_ENC, 32'h0);
            chk("pending", resp_rdata, {8'h00, exp_id[r]});
            chk("quiet", {prio_drop, deactivate, 6'h0, done_id}, 32'h0000_0040);
        end
        hp_group0_reason = EOIHP_HP_VALID;
        identifier_width_24 = 1'b0;
        go(1'b0, HPP_ENC, 32'h0);
        chk("narrow", resp_rdata, 32'h0000_3456);
        identifier_width_24 = 1'b1;
        go(1'b1, HPP_ENC, 32'h40);
        chk("wr pending", {31'h0, resp_undef}, 32'h1);
        go(1'b0, EOI_ENC, 32'h0);
        chk("rd completion", {31'h0, resp_undef}, 32'h1);
        go(1'b1, 14'h0660, 32'h40);
        chk("bad op2", {31'h0, resp_undef}, 32'h1);
        go(1'b1, 14'h0e61, 32'h40);
        chk("bad op1", {31'h0, resp_undef}, 32'h1);
    endtask : sc_pend
    // Main sequence
    initial begin
        rst_n = 1'b0;
        mode_v = 4'h0;
        wr_grp = 1'b1;
        identifier_width_24 = 1'b1;
        hp_group0_id = 24'h00_0000;
        hp_group0_reason = EOIHP_HP_VALID;
        ctx(EL1, 1'b0, 1'b1, 7'h07);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("reset", {resp_valid, resp_undef, resp_trap, resp_virtual, prio_drop, deactivate, 2'h0, done_id}, 32'h0);
        mode_case(EL1, 1'b0, 1'b0, 4'h8);
        mode_case(EL1, 1'b1, 1'b0, 4'h8);
        mode_case(EL3, 1'b0, 1'b1, 4'h4);
        mode_case(EL1, 1'b0, 1'b1, 4'h2);
        mode_case(EL2, 1'b1, 1'b1, 4'h1);
        mode_case(EL1, 1'b1, 1'b1, 4'h1);
        sc_ids;
        acc(EL0, 1'b0, 1'b1, 7'h07, 3'h4, 2'h0);
        acc(EL1, 1'b1, 1'b1, 7'h0f, 3'h4, 2'h0);
        acc(EL1, 1'b0, 1'b1, 7'h06, 3'h2, EL1);
        acc(EL2, 1'b1, 1'b1, 7'h05, 3'h2, EL2);
        acc(EL3, 1'b0, 1'b1, 7'h03, 3'h2, EL3);
        acc(EL1, 1'b1, 1'b1, 7'h27, 3'h2, EL2);
        acc(EL1, 1'b0, 1'b1, 7'h47, 3'h2, EL3);
        acc(EL2, 1'b1, 1'b1, 7'h47, 3'h2, EL3);
        acc(EL1, 1'b1, 1'b1, 7'h47, 3'h2, EL3);
        acc(EL1, 1'b1, 1'b1, 7'h17, 3'h1, 2'h0);
        acc(EL1, 1'b1, 1'b1, 7'h57, 3'h1, 2'h0);
        acc(EL1, 1'b0, 1'b0, 7'h47, 3'h0, 2'h0);
        acc(EL1, 1'b1, 1'b1, 7'h07, 3'h0, 2'h0);
        sc_pend;
        end_sim;
    end
    // Hang guard
    initial begin
        #(2000 * 50);
        num_errors++;
        end_sim;
    end
endmodule : tb
